// [src/fcsm_cyc_if.sv]
// Purpose: one flash bus cycle request between sequencer and pin engine
// Assumes: single clock domain
// Notes:   ack is a one-cycle pulse at the end of the cycle
`timescale 1ns/1ps
`default_nettype none
interface fcsm_cyc_if #(parameter int ADDR_W = 21);
  logic              req;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic [15:0]       wdata;
  logic              ack;
  logic [15:0]       rdata;
  modport ctrl (output req, wr, addr, wdata, input ack, rdata);
  modport eng  (input req, wr, addr, wdata, output ack, rdata);
endinterface
`default_nettype wire

// [src/fcsm_host.sv]
// Purpose: APB-controlled host that issues flash command sequences
// Assumes: flash inputs synchronous to pclk, 16-bit data bus
// Notes:   one operation at a time; status shows modes and readiness
`timescale 1ns/1ps
`default_nettype none
// Function
// - identification mode left only through reset write or hardware reset
// - program is unlock pair, A0h, address data
// - unlock pair then 20h enters bypass
// - bypass program is A0h then address data
// - bypass exit is 90h then 00h
// - chip erase is six writes ending 10h
// - sector erase six writes, sector address 30h
// - added sectors refused once window expired
module fcsm_host
  import fcsm_pkg::*;
#(
  parameter int ADDR_W     = 21,
  parameter int WINDOW_CNT = WINDOW_CYC
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [15:0]       flash_dq_in,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n,
  output logic                   flash_byte_n,
  output logic                   flash_reset_n,
  input  wire logic              ready_busy_out
);
  if (ADDR_W < 12 || ADDR_W > 24) $error("fcsm_host: ADDR_W out of range");
  if (WINDOW_CNT < 1 || WINDOW_CNT > 65535) $error("fcsm_host: WINDOW_CNT out of range");

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_REQ  = 2'b01,
    S_WAIT = 2'b10
  } fcsm_state_t;

  // ****************************************
  // registers
  // ****************************************
  fcsm_state_t       state_reg;
  fcsm_op_t          op_reg;
  logic [2:0]        step_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [15:0]       wdata_reg;
  logic [15:0]       rdata_reg;
  logic [1:0]        config_reg;
  logic              bypass_reg;
  logic              id_reg;
  logic              refused_reg;
  logic [15:0]       window_reg;

  fcsm_cyc_if #(.ADDR_W(ADDR_W)) cyc ();

  // ****************************************
  // apb decode
  // ****************************************
  wire access   = psel && penable;
  wire wr_commit = access && pready && pwrite;
  wire mapped   = (paddr == OFS_CMD) || (paddr == OFS_ADDR) || (paddr == OFS_WDATA) ||
                  (paddr == OFS_RDATA) || (paddr == OFS_STATUS) || (paddr == OFS_CONFIG);
  wire cmd_wr   = wr_commit && (paddr == OFS_CMD);
  wire busy     = (state_reg != S_IDLE);
  wire window_open = (window_reg != 16'h0000);
  wire byte_mode   = config_reg[CFG_BYTE_BIT];
  fcsm_op_t new_op;
  assign new_op = fcsm_op_t'(pwdata[3:0]);

  // ****************************************
  // command acceptance
  // ****************************************
  wire op_known  = (pwdata[3:0] <= 4'h8);
  // bypass mode takes only its own exit, a plain reset would be ignored
  wire always_ok = (new_op == OP_READ) ||
                   ((new_op == OP_RESET) && !bypass_reg);
  wire flash_idle = ready_busy_out && !config_reg[CFG_HWRST_BIT];
  wire mode_ok   = id_reg ? 1'b0 :
                   bypass_reg ? ((new_op == OP_PROGRAM) || (new_op == OP_BYP_EXIT)) :
                   (new_op == OP_ADD_SECTOR) ? window_open :
                   (new_op != OP_BYP_EXIT);
  // busy flash: program or erase underway takes only read and, outside bypass, reset
  wire accept    = cmd_wr && !busy && op_known &&
                   (always_ok || (mode_ok && flash_idle));
  wire refuse    = cmd_wr && !accept;

  // ****************************************
  // sequence table
  // ****************************************
  wire [ADDR_W-1:0] u1 = ADDR_W'(byte_mode ? ADDR_U1_BYTE : ADDR_U1_WORD);
  wire [ADDR_W-1:0] u2 = ADDR_W'(byte_mode ? ADDR_U2_BYTE : ADDR_U2_WORD);
  logic [ADDR_W-1:0] st_addr;
  logic [15:0]       st_data;
  logic              st_last;
  logic              st_read;

  always_comb begin
    st_addr = u1;
    st_data = 16'h0000;
    st_last = 1'b0;
    st_read = 1'b0;
    if (step_reg == 3'd1) st_addr = u2;
    if (step_reg == 3'd0) st_data = {8'h00, CODE_UNLOCK1};
    if (step_reg == 3'd1) st_data = {8'h00, CODE_UNLOCK2};
    case (op_reg)
      OP_READ: begin
        st_addr = addr_reg;
        st_read = 1'b1;
        st_last = 1'b1;
      end
      OP_RESET: begin
        st_addr = addr_reg;
        st_data = {8'h00, CODE_RESET};
        st_last = 1'b1;
      end
      OP_AUTOSELECT: if (step_reg == 3'd2) begin
        st_data = {8'h00, CODE_ID};
        st_last = 1'b1;
      end
      OP_BYP_ENTER: if (step_reg == 3'd2) begin
        st_data = {8'h00, CODE_BYPASS};
        st_last = 1'b1;
      end
      OP_BYP_EXIT: begin
        st_addr = u1;
        st_data = (step_reg == 3'd0) ? {8'h00, CODE_ID} : {8'h00, CODE_BYP_END};
        st_last = (step_reg == 3'd1);
      end
      OP_PROGRAM: begin
        if (bypass_reg) begin
          st_addr = (step_reg == 3'd0) ? u1 : addr_reg;
          st_data = (step_reg == 3'd0) ? {8'h00, CODE_PROG} : wdata_reg;
          st_last = (step_reg == 3'd1);
        end else if (step_reg == 3'd2) begin
          st_data = {8'h00, CODE_PROG};
        end else if (step_reg == 3'd3) begin
          st_addr = addr_reg;
          st_data = wdata_reg;
          st_last = 1'b1;
        end
      end
      OP_CHIP_ERASE, OP_SECT_ERASE: begin
        case (step_reg)
          3'd2: st_data = {8'h00, CODE_ERASE};
          3'd3: st_data = {8'h00, CODE_UNLOCK1};
          3'd4: begin
            st_addr = u2;
            st_data = {8'h00, CODE_UNLOCK2};
          end
          3'd5: begin
            st_last = 1'b1;
            if (op_reg == OP_CHIP_ERASE) begin
              st_data = {8'h00, CODE_CHIP};
            end else begin
              st_addr = addr_reg;
              st_data = {8'h00, CODE_SECTOR};
            end
          end
          default: ;
        endcase
      end
      OP_ADD_SECTOR: begin
        st_addr = addr_reg;
        st_data = {8'h00, CODE_SECTOR};
        st_last = 1'b1;
      end
      default: st_last = 1'b1;
    endcase
  end

  assign cyc.req   = (state_reg == S_REQ);
  assign cyc.wr    = !st_read;
  assign cyc.addr  = st_addr;
  assign cyc.wdata = st_data;

  // ****************************************
  // sequencer: one step per engine cycle, in order
  // ****************************************
  wire seq_done = cyc.ack && st_last;
  wire hw_reset = config_reg[CFG_HWRST_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= S_IDLE;
      op_reg    <= OP_READ;
      step_reg  <= 3'd0;
    end else begin
      case (state_reg)
        S_IDLE: if (accept) begin
          op_reg    <= new_op;
          step_reg  <= 3'd0;
          state_reg <= S_REQ;
        end
        S_REQ: state_reg <= S_WAIT;
        S_WAIT: if (cyc.ack) begin
          step_reg  <= step_reg + 3'd1;
          state_reg <= st_last ? S_IDLE : S_REQ;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  // ****************************************
  // mode tracking and window timer
  // ****************************************
  wire win_start = seq_done && ((op_reg == OP_SECT_ERASE) || (op_reg == OP_ADD_SECTOR));
  wire win_kill  = seq_done && !win_start && (op_reg != OP_READ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bypass_reg <= 1'b0;
      id_reg     <= 1'b0;
      window_reg <= 16'h0000;
    end else begin
      if (hw_reset || (seq_done && op_reg == OP_RESET)) begin
        bypass_reg <= 1'b0;
        id_reg     <= 1'b0;
      end else if (seq_done) begin
        if (op_reg == OP_AUTOSELECT) id_reg <= 1'b1;
        if (op_reg == OP_BYP_ENTER) bypass_reg <= 1'b1;
        if (op_reg == OP_BYP_EXIT) bypass_reg <= 1'b0;
      end
      if (hw_reset || win_kill) window_reg <= 16'h0000;
      else if (win_start) window_reg <= 16'(WINDOW_CNT);
      else if (window_open) window_reg <= window_reg - 16'h0001;
    end
  end

  // ****************************************
  // apb registers
  // ****************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      OFS_CMD:    rd_mux = {28'h0000000, op_reg};
      OFS_ADDR:   rd_mux = 32'(addr_reg);
      OFS_WDATA:  rd_mux = {16'h0000, wdata_reg};
      OFS_RDATA:  rd_mux = {16'h0000, rdata_reg};
      OFS_STATUS: begin
        rd_mux[ST_BUSY_BIT]    = busy;
        rd_mux[ST_READY_BIT]   = ready_busy_out;
        rd_mux[ST_BYPASS_BIT]  = bypass_reg;
        rd_mux[ST_ID_BIT]      = id_reg;
        rd_mux[ST_WINDOW_BIT]  = window_open;
        rd_mux[ST_REFUSED_BIT] = refused_reg;
      end
      OFS_CONFIG: rd_mux = {30'h0, config_reg};
      default:    rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      prdata        <= 32'h0000_0000;
      addr_reg      <= '0;
      wdata_reg     <= 16'h0000;
      rdata_reg     <= 16'h0000;
      config_reg    <= CONFIG_RESET;
      refused_reg   <= 1'b0;
      flash_byte_n  <= 1'b1;
      flash_reset_n <= 1'b1;
    end else begin
      pready  <= access && !pready;
      pslverr <= access && !pready && !mapped;
      if (access && !pready) prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      if (wr_commit && paddr == OFS_ADDR && !busy) addr_reg <= pwdata[ADDR_W-1:0];
      if (wr_commit && paddr == OFS_WDATA && !busy) wdata_reg <= pwdata[15:0];
      if (wr_commit && paddr == OFS_CONFIG && !busy) config_reg <= pwdata[1:0];
      if (seq_done && op_reg == OP_READ) rdata_reg <= cyc.rdata;
      if (refuse) refused_reg <= 1'b1;
      else if (accept) refused_reg <= 1'b0;
      flash_byte_n  <= !config_reg[CFG_BYTE_BIT];
      flash_reset_n <= !config_reg[CFG_HWRST_BIT];
    end
  end

  // ****************************************
  // pin engine
  // ****************************************
  fcsm_pin_engine #(.ADDR_W(ADDR_W)) u_engine (
    .pclk         (pclk),
    .presetn      (presetn),
    .cyc          (cyc),
    .flash_addr   (flash_addr),
    .flash_dq_in  (flash_dq_in),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );
endmodule
`default_nettype wire

// [src/fcsm_pin_engine.sv]
// Purpose: drives one write or read cycle on the flash pins
// Assumes: flash inputs synchronous to pclk
// Notes:   chip enable framing the write enable pulse
`timescale 1ns/1ps
`default_nettype none
module fcsm_pin_engine
  import fcsm_pkg::*;
#(
  parameter int ADDR_W = 21
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // cycle requests
  fcsm_cyc_if.eng                cyc,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr,
  input  wire logic [15:0]       flash_dq_in,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_ce_n,
  output logic                   flash_we_n,
  output logic                   flash_oe_n
);
  if (ADDR_W < 12 || ADDR_W > 24) $error("fcsm_pin_engine: ADDR_W out of range");

  typedef enum logic [2:0] {
    E_IDLE  = 3'b000,
    E_SETUP = 3'b001,
    E_PULSE = 3'b010,
    E_HOLD  = 3'b011,
    E_READ  = 3'b100
  } fcsm_eng_t;

  fcsm_eng_t  state_reg;
  logic [7:0] cnt_reg;
  logic       ack_reg;
  logic [15:0] rdata_reg;
  wire        cnt_done = (cnt_reg == 8'h00);

  assign cyc.ack   = ack_reg;
  assign cyc.rdata = rdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= E_IDLE;
      cnt_reg      <= 8'h00;
      ack_reg      <= 1'b0;
      rdata_reg    <= 16'h0000;
      flash_addr   <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end else begin
      ack_reg <= 1'b0;
      if (!cnt_done) cnt_reg <= cnt_reg - 8'h01;
      case (state_reg)
        E_IDLE: begin
          if (cyc.req && !ack_reg) begin
            flash_addr   <= cyc.addr;
            flash_dq_out <= cyc.wdata;
            flash_dq_oe  <= cyc.wr;
            flash_ce_n   <= 1'b0;
            if (cyc.wr) begin
              state_reg <= E_SETUP;
              cnt_reg   <= 8'(SETUP_CYC - 1);
            end else begin
              flash_oe_n <= 1'b0;
              state_reg  <= E_READ;
              cnt_reg    <= 8'(ACCESS_CYC - 1);
            end
          end
        end
        E_SETUP: if (cnt_done) begin
          // address taken by the device at the later falling strobe
          flash_we_n <= 1'b0;
          state_reg  <= E_PULSE;
          cnt_reg    <= 8'(PULSE_CYC - 1);
        end
        E_PULSE: if (cnt_done) begin
          // data taken at this rising edge, still driven afterwards
          flash_we_n <= 1'b1;
          state_reg  <= E_HOLD;
          cnt_reg    <= 8'(HOLD_CYC - 1);
        end
        E_HOLD: if (cnt_done) begin
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          ack_reg     <= 1'b1;
          state_reg   <= E_IDLE;
        end
        E_READ: if (cnt_done) begin
          rdata_reg  <= flash_dq_in;
          flash_oe_n <= 1'b1;
          flash_ce_n <= 1'b1;
          ack_reg    <= 1'b1;
          state_reg  <= E_IDLE;
        end
        default: state_reg <= E_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/fcsm_pkg.sv]
// Purpose: shared constants for the flash command sequencer host
// Assumes: 100 MHz pclk, 16-bit flash data bus
// Notes:   offsets, codes and timing counts live here only
package fcsm_pkg;
  // ****************************************
  // clock and flash pin timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_SETUP_NS    = 20;
  localparam int T_PULSE_NS    = 50;
  localparam int T_HOLD_NS     = 30;
  localparam int T_ACCESS_NS   = 80;
  localparam int SETUP_CYC     = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC     = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC      = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // sector loading window, kept short of the device limit
  localparam int WINDOW_US     = 50;
  localparam int WINDOW_MARGIN = 90;
  localparam int WINDOW_CYC    = (WINDOW_US * 1000 / CLK_PERIOD_NS) * WINDOW_MARGIN / 100;

  // ****************************************
  // register offsets and fields
  // ****************************************
  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_ADDR   = 8'h04;
  localparam logic [7:0] OFS_WDATA  = 8'h08;
  localparam logic [7:0] OFS_RDATA  = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CONFIG = 8'h14;
  localparam int ST_BUSY_BIT    = 0;
  localparam int ST_READY_BIT   = 1;
  localparam int ST_BYPASS_BIT  = 2;
  localparam int ST_ID_BIT      = 3;
  localparam int ST_WINDOW_BIT  = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int CFG_BYTE_BIT   = 0;
  localparam int CFG_HWRST_BIT  = 1;
  localparam logic [1:0] CONFIG_RESET = 2'h0;

  // ****************************************
  // host operations
  // ****************************************
  typedef enum logic [3:0] {
    OP_READ       = 4'h0,
    OP_RESET      = 4'h1,
    OP_AUTOSELECT = 4'h2,
    OP_PROGRAM    = 4'h3,
    OP_BYP_ENTER  = 4'h4,
    OP_BYP_EXIT   = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_SECT_ERASE = 4'h7,
    OP_ADD_SECTOR = 4'h8
  } fcsm_op_t;

  // ****************************************
  // flash command codes and unlock addresses
  // ****************************************
  localparam logic [7:0]  CODE_UNLOCK1 = 8'haa;
  localparam logic [7:0]  CODE_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CODE_ID      = 8'h90;
  localparam logic [7:0]  CODE_PROG    = 8'ha0;
  localparam logic [7:0]  CODE_ERASE   = 8'h80;
  localparam logic [7:0]  CODE_CHIP    = 8'h10;
  localparam logic [7:0]  CODE_SECTOR  = 8'h30;
  localparam logic [7:0]  CODE_RESET   = 8'hf0;
  localparam logic [7:0]  CODE_BYPASS  = 8'h20;
  localparam logic [7:0]  CODE_BYP_END = 8'h00;
  localparam logic [11:0] ADDR_U1_WORD = 12'h555;
  localparam logic [11:0] ADDR_U2_WORD = 12'h2aa;
  localparam logic [11:0] ADDR_U1_BYTE = 12'haaa;
  localparam logic [11:0] ADDR_U2_BYTE = 12'h555;
endpackage

// [test/fcsm_flash_model.sv]
// Purpose: flash device model at the host pins
// Assumes: 16 words, four sectors of four
// Notes:   no suspend or time limit; timers in ns
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
  parameter logic [47:0] IDS    = 48'h0012_0034_0056, // arbitrary
  parameter int          WIN_NS = 50000
) (
  // host pins
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_byte_n,
  input  wire logic        flash_reset_n,
  // wire level, status
  output logic [15:0]      flash_dq_in,
  output logic             ready_busy_out
);
  logic [15:0]     mem [16];
  logic [15:0]     q;
  logic [20:0]     a;
  logic [3:0]      ers = 0;
  logic            id  = 0;
  logic            byp = 0;
  int              st  = 0;
  time             bt  = 0;
  time             wt  = 0;
  wire logic       u1  = a[11:0] == (flash_byte_n ? 12'h555 : 12'haaa);
  wire logic       u2  = a[11:0] == (flash_byte_n ? 12'h2aa : 12'h555);
  wire logic [7:0] d   = flash_dq_in[7:0];
  initial mem = '{default: 16'hffff};
  always_comb begin
    q = mem[flash_addr[3:0]];
    if (id) begin
      case (flash_addr[7:0])
        8'h00:   q = IDS[47:32];
        8'h01:   q = IDS[31:16];
        8'h11:   q = IDS[15:0];
        8'h02:   q = {15'h0, flash_addr[12]};
        default: q = 16'h0;
      endcase
    end
  end
  // released bus shows the inverse, never stale data
  assign flash_dq_in = flash_dq_oe ? flash_dq_out : !flash_ce_n && !flash_oe_n ? q : ~q;
  always @(negedge flash_we_n) a = flash_addr;
  always @(negedge flash_reset_n) begin
    {id, byp, ers} = '0;
    st = 0;
    bt = 0;
  end
  task automatic prog;
    mem[a[3:0]] &= flash_dq_in;
    bt = $time + 3000;
    st = 0;
  endtask
  always @(posedge flash_we_n) begin
    if (!flash_ce_n && ready_busy_out && flash_reset_n) begin
      if (byp) begin
        case (st)
          3: prog();
          8: begin
            byp = d != 8'h00;
            st = 0;
          end
          default: st = d == 8'ha0 ? 3 : d == 8'h90 ? 8 : 0;
        endcase
      end else if (d == 8'hf0) begin
        {id, ers} = '0;
        st = 0;
      end else begin
        case (st)
          0: st = d == 8'haa && u1 ? 1 : 0;
          1: st = d == 8'h55 && u2 ? 2 : 0;
          2: begin
            st = !u1 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
            id |= u1 && d == 8'h90;
            byp = u1 && d == 8'h20;
          end
          3: prog();
          4: st = d == 8'haa && u1 ? 5 : 0;
          5: st = d == 8'h55 && u2 ? 6 : 0;
          default: if (d == 8'h30) begin
            ers[a[3:2]] = 1;
            wt = $time + WIN_NS;
            st = 7;
          end else begin
            if (st == 6 && d == 8'h10 && u1) mem = '{default: 16'hffff};
            if (st == 6 && d == 8'h10 && u1) bt = $time + 2000;
            st = 0;
            ers = 0;
          end
        endcase
      end
    end
  end
  always #10 begin
    if (st == 7 && $time >= wt) begin
      for (int i = 0; i < 16; i++)
        if (ers[i / 4]) mem[i] = 16'hffff;
      ers = 0;
      st = 0;
      bt = $time + 2000;
    end
    ready_busy_out = $time >= bt;
  end
endmodule
`default_nettype wire

// [test/fcsm_host_properties.sv]
// Purpose: port checks for fcsm_host
// Assumes: one pclk domain
// Notes:   bound to every fcsm_host
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_properties #(
  parameter int ADDR_W = 21
) (
  // apb
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  // flash pins
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic [15:0]       flash_dq_out,
  input wire logic              flash_dq_oe,
  input wire logic              flash_ce_n,
  input wire logic              flash_we_n,
  input wire logic              flash_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // apb answer
  // ****
  property p_ans; psel && $rose(penable) |-> !pready ##1 pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("pready timing wrong");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  // ****
  // flash strobes
  // ****
  property p_we; !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n; endproperty
  a_we: assert property (p_we) else $error("write pulse outside frame");
  property p_pulse; $fell(flash_we_n) |-> !flash_we_n [*5] ##1 flash_we_n; endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse width");
  property p_setup; $fell(flash_we_n) |-> !$past(flash_ce_n, 2); endproperty
  a_setup: assert property (p_setup) else $error("address setup short");
  property p_hold; $rose(flash_we_n) |-> !flash_ce_n [*3] ##[1:4] flash_ce_n; endproperty
  a_hold: assert property (p_hold) else $error("data hold wrong");
  property p_stab;
    !flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr) && $stable(flash_dq_out);
  endproperty
  a_stab: assert property (p_stab) else $error("pins moved in frame");
  property p_rd; $fell(flash_oe_n) |-> (!flash_ce_n && !flash_dq_oe) [*8] ##1 flash_oe_n; endproperty
  a_rd: assert property (p_rd) else $error("read cycle wrong");
endmodule
bind fcsm_host fcsm_host_properties #(.ADDR_W(ADDR_W)) u_props (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .flash_addr,
  .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n, .flash_oe_n
);
`default_nettype wire

// [test/fcsm_host_tb_top.sv]
// Purpose: self-checking bench for fcsm_host
// Assumes: flash model on the pins, short window
// Notes:   APB tasks drive every order
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_tb_top
  import fcsm_pkg::*;
;
  localparam logic [47:0] IDS = 48'h005a_0c3c_0a11; // arbitrary
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_in, flash_dq_out;
  logic        flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n, flash_byte_n;
  logic        flash_reset_n, ready_busy_out;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [20:0] ida [5] = '{21'h0, 21'h1, 21'h11, 21'h1002, 21'h2};
  logic [15:0] idv [5] = '{IDS[47:32], IDS[31:16], IDS[15:0], 16'h1, 16'h0};
  fcsm_host #(.WINDOW_CNT(200)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .flash_addr, .flash_dq_in, .flash_dq_out, .flash_dq_oe, .flash_ce_n,
    .flash_we_n, .flash_oe_n, .flash_byte_n, .flash_reset_n, .ready_busy_out
  );
  fcsm_flash_model #(.IDS(IDS), .WIN_NS(2500)) u_flash (
    .flash_addr, .flash_dq_out, .flash_dq_oe, .flash_ce_n, .flash_we_n,
    .flash_oe_n, .flash_byte_n, .flash_reset_n, .flash_dq_in, .ready_busy_out
  );
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // ****
  // tasks
  // ****
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic go(input logic [3:0] o, input logic [31:0] ad, input logic [31:0] wd);
    apb(1, OFS_ADDR, ad);
    apb(1, OFS_WDATA, wd);
    apb(1, OFS_CMD, {28'h0, o});
  endtask
  task automatic run(input logic [3:0] o, input logic [31:0] ad, input logic [31:0] wd);
    go(o, ad, wd);
    do apb(0, OFS_STATUS, 0); while ({q[ST_READY_BIT], q[ST_BUSY_BIT]} !== 2'b10);
  endtask
  task automatic peek(input logic [31:0] ad, input logic [15:0] e);
    run(OP_READ, ad, 0);
    apb(0, OFS_RDATA, 0);
    chk("rdata", {16'h0, e}, q);
  endtask
  task automatic refu(input logic [3:0] o);
    apb(1, OFS_CMD, {28'h0, o});
    apb(0, OFS_STATUS, 0);
    chk("refused", 1, q[ST_REFUSED_BIT]);
  endtask
  // ****
  // sequence
  // ****
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    apb(0, OFS_STATUS, 0);
    chk("status", 32'h2, q);
    apb(0, OFS_CONFIG, 0);
    chk("config", CONFIG_RESET, q);
    chk("pins", 6'h3f, {flash_ce_n, flash_we_n, flash_oe_n, !flash_dq_oe, flash_byte_n, flash_reset_n});
    apb(0, 8'h40, 0);
    chk("slverr", 1, err);
    refu(4'h9);
    run(OP_PROGRAM, 3, 16'h1234);
    peek(3, 16'h1234);
    go(OP_PROGRAM, 3, 16'h00ff);
    do apb(0, OFS_STATUS, 0); while (q[ST_BUSY_BIT] !== 1'b0);
    refu(OP_PROGRAM);
    chk("ready", 0, q[ST_READY_BIT]);
    peek(3, 16'h0034);
    run(OP_AUTOSELECT, 0, 0);
    chk("id", 1, q[ST_ID_BIT]);
    foreach (ida[i]) peek(ida[i], idv[i]);
    refu(OP_PROGRAM);
    run(OP_RESET, 21'h1abc, 0);
    chk("clear", 0, q[ST_REFUSED_BIT]);
    peek(3, 16'h0034);
    run(OP_BYP_ENTER, 0, 0);
    chk("bypass", 1, q[ST_BYPASS_BIT]);
    run(OP_PROGRAM, 6, 16'h5a5a);
    run(OP_PROGRAM, 8, 16'h0f0f);
    refu(OP_CHIP_ERASE);
    refu(OP_RESET);
    chk("bypass", 1, q[ST_BYPASS_BIT]);
    run(OP_BYP_EXIT, 0, 0);
    refu(OP_BYP_EXIT);
    peek(6, 16'h5a5a);
    run(OP_SECT_ERASE, 4, 0);
    chk("window", 1, q[ST_WINDOW_BIT]);
    run(OP_ADD_SECTOR, 0, 0);
    repeat (300) @(posedge pclk);
    refu(OP_ADD_SECTOR);
    peek(6, 16'hffff);
    peek(3, 16'hffff);
    peek(8, 16'h0f0f);
    run(OP_CHIP_ERASE, 0, 0);
    peek(8, 16'hffff);
    apb(1, OFS_CONFIG, 1);
    repeat (2) @(posedge pclk);
    chk("byte_n", 0, flash_byte_n);
    run(OP_AUTOSELECT, 0, 0);
    peek(0, IDS[47:32]);
    run(OP_RESET, 0, 0);
    apb(1, OFS_CONFIG, 2);
    repeat (2) @(posedge pclk);
    chk("reset_n", 0, flash_reset_n);
    refu(OP_AUTOSELECT);
    apb(1, OFS_CONFIG, 0);
    run(OP_PROGRAM, 2, 16'h00c3);
    peek(2, 16'h00c3);
    report_and_stop();
  end
endmodule
`default_nettype wire
